// file: hdl/cgls_top.sv
// Gate, latch and synchronization control of a 32-bit signed count unit.
//
// Notes on behaviour
// - A parameter gives the input line one of five roles, latch in two flavours.
// - For plain input or hardware gate, a parameter inverts the sensed level.
// - The input level is reported in a status bit in every role.
// - Software gate opens on request rising edge, closes when request is cleared.
// - Hardware gate opens on input rising edge and closes on falling edge.
// - Internal gate is software AND hardware gate; counting only while open.
// - In count-once mode a limit overflow or underflow closes the gate.
// - Cancel mode restarts from load value on reopen except in latch-retrigger; interrupt mode resumes unless a reload parameter is set.
// - Software-only gate opening continues or reloads, chosen by parameter.
// - Isochronous gate opening request acts at next output instant; feedback sampled at input instant.
// - Software gate opening while hardware gate open continues without reload.
// - Hardware gate opening continues or reloads, chosen by parameter.
// - Isochronous: if hardware gate opens late, counting waits for it.
// - Latch-retrigger: rising edge captures count then reloads load value.
// - Latch value resets to zero, shown in feedback, untouched by gate or loads.
// - Latch-retrigger: closing software gate only interrupts; input keeps capturing.
// - Isochronous latch feedback holds the last capture before the input instant.
// - Plain latch: start from load value at gate open; edges capture without reload.
// - Plain latch: gate close cancels or interrupts; input keeps capturing.
// - Wide feedback carries the live count beside the latched value.
// - Sync role: gated rising edge loads counter, once only or every edge.
// - Each sync sets done status and lamp; status reset request clears both.
// - The counter is signed 32 bits over the full range.
`timescale 1ns/1ps
module cgls_top #(
   parameter cgls_pkg::cgls_di_role_t DI_ROLE = cgls_pkg::CGLS_DI_INPUT,
   parameter bit DI_INVERT = 1'b0,
   parameter cgls_pkg::cgls_gate_func_t GATE_FUNC = cgls_pkg::CGLS_GATE_CANCEL,
   parameter cgls_pkg::cgls_count_mode_t COUNT_MODE = cgls_pkg::CGLS_MODE_ENDLESS,
   parameter bit SW_OPEN_RELOAD = 1'b1,
   parameter bit HW_OPEN_RELOAD = 1'b1,
   parameter bit SYNC_PERIODIC = 1'b0,
   parameter bit WIDE_FEEDBACK = 1'b1
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic aux_input_line_in,
   input wire logic count_pulse_in,
   input wire logic count_up_in,
   input wire logic iso_enable_in,
   input wire logic ti_strobe_in,
   input wire logic to_strobe_in,
   input wire cgls_pkg::cgls_ctrl_t ctrl_in,
   output cgls_pkg::cgls_fb_t feedback_out,
   output logic alignment_lamp_out
);
   import cgls_pkg::*;

   // Role decode.
   // Two latch flavours share the capture path and differ in what an edge and a gate opening reload.
   localparam bit ROLE_HWGATE = (DI_ROLE == CGLS_DI_HWGATE);
   localparam bit ROLE_LATCH = (DI_ROLE == CGLS_DI_LATCH);
   localparam bit ROLE_RETRIG = (DI_ROLE == CGLS_DI_RETRIG);
   localparam bit ROLE_SYNC = (DI_ROLE == CGLS_DI_SYNC);
   localparam bit ROLE_LATCHING = ROLE_LATCH | ROLE_RETRIG;
   // Inversion only applies where the level itself carries meaning.
   localparam bit USE_INVERT = DI_INVERT & ((DI_ROLE == CGLS_DI_INPUT) | ROLE_HWGATE);
   localparam bit CANCELING = (GATE_FUNC == CGLS_GATE_CANCEL);
   localparam bit MODE_ONCE = (COUNT_MODE == CGLS_MODE_ONCE);
   localparam bit MODE_PERIODIC = (COUNT_MODE == CGLS_MODE_PERIODIC);

   // Conditioned view of the input line: its level and single-cycle edge events.
   logic di_level;
   logic di_rise;
   logic di_fall;

   // Gate state, arming flags, the counter and its load and latch values.
   logic swreq_prev_q;
   logic sw_pending_q;
   logic software_gate_request_q;
   logic hw_gate_q;
   logic retrig_armed_q;
   logic sync_once_q;
   logic sync_done_q;
   logic signed [CGLS_CW-1:0] count_q;
   logic signed [CGLS_CW-1:0] count_d;
   logic signed [CGLS_CW-1:0] load_q;
   logic signed [CGLS_CW-1:0] latch_q;

   // Events of this cycle, derived from registered state and the present inputs.
   logic swreq_rise;
   logic swreq_fall;
   logic sw_open_now;
   logic hw_ok;
   logic int_gate;
   logic hw_open_ev;
   logic open_reload;
   logic sw_open_ev;
   logic retrig_ev;
   logic latch_ev;
   logic sync_ev;
   logic step_en;
   logic signed [CGLS_CW-1:0] stepped;
   logic limit_hit;
   logic once_close;
   cgls_fb_t fb_d;
   cgls_fb_t fb_q;

   // The input line is taken as synchronous, yet it still passes two flops here.
   // A line from another clock domain would otherwise upset the edge events.
   cgls_edge u_edge (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .pin_in(aux_input_line_in),
      .invert_in(USE_INVERT),
      .level_out(di_level),
      .rise_out(di_rise),
      .fall_out(di_fall)
   );

   // Software gate request edges.
   always_comb begin
      swreq_rise = ctrl_in.software_gate_request & ~swreq_prev_q;
      swreq_fall = ~ctrl_in.software_gate_request & swreq_prev_q;
   end

   // Previous request level, so that only a fresh rising request opens the gate.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         swreq_prev_q <= 1'b0;
      end else begin
         swreq_prev_q <= ctrl_in.software_gate_request;
      end
   end

   // In isochronous operation an opening request waits for the next output instant.
   // Leaving isochronous operation drops a waiting request, so that a later output
   // instant cannot open the gate on a stale request.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sw_pending_q <= 1'b0;
      end else if (swreq_fall || sw_open_now || !iso_enable_in) begin
         sw_pending_q <= 1'b0;
      end else if (swreq_rise && iso_enable_in) begin
         sw_pending_q <= 1'b1;
      end
   end

   // Outside isochronous operation the request edge opens the gate at the next clock.
   always_comb begin
      if (iso_enable_in) begin
         sw_open_now = (sw_pending_q | swreq_rise) & to_strobe_in & ~swreq_fall;
      end else begin
         sw_open_now = swreq_rise;
      end
   end

   // A held request never reopens the gate; only a fresh rising edge does.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         software_gate_request_q <= 1'b0;
      end else if (swreq_fall || once_close) begin
         software_gate_request_q <= 1'b0;
      end else if (sw_open_now) begin
         software_gate_request_q <= 1'b1;
      end
   end

   // The hardware gate tracks the line on its own, whatever the software gate does.
   // Keeping the two apart lets the internal gate stay a plain AND of both.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hw_gate_q <= 1'b0;
      end else if (ROLE_HWGATE && di_rise) begin
         hw_gate_q <= 1'b1;
      end else if (ROLE_HWGATE && di_fall) begin
         hw_gate_q <= 1'b0;
      end
   end

   // A late hardware opening simply holds the AND low until it arrives.
   always_comb begin
      hw_ok = ROLE_HWGATE ? hw_gate_q : 1'b1;
      int_gate = software_gate_request_q & hw_ok;
   end

   // Gate opening events and the reload they may cause.
   // A reload needs a genuine opening; a request arriving while open changes nothing.
   always_comb begin
      sw_open_ev = sw_open_now & ~software_gate_request_q;
      hw_open_ev = ROLE_HWGATE & di_rise & ~hw_gate_q & software_gate_request_q;
      open_reload = 1'b0;
      if (ROLE_HWGATE) begin
         if (hw_open_ev) begin
            open_reload = HW_OPEN_RELOAD | CANCELING;
         end
         // Opening the software gate behind an open hardware gate keeps the count.
         if (sw_open_ev && hw_gate_q) begin
            open_reload = 1'b0;
         end
      end else if (ROLE_LATCH) begin
         open_reload = sw_open_ev & (CANCELING | ~retrig_armed_q);
      end else if (ROLE_RETRIG) begin
         open_reload = 1'b0;
      end else begin
         open_reload = sw_open_ev & (SW_OPEN_RELOAD | CANCELING);
      end
   end

   // Capturing roles stay active with the gate closed once counting has been enabled.
   // The arming flag is only cleared by reset, so the input stays live while closed.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         retrig_armed_q <= 1'b0;
      end else if (sw_open_ev) begin
         retrig_armed_q <= 1'b1;
      end
   end

   // Sync loads need the open software gate and the enable bit; once-only waits for re-arm.
   always_comb begin
      retrig_ev = ROLE_RETRIG & di_rise & (retrig_armed_q | software_gate_request_q);
      latch_ev = ROLE_LATCH & di_rise;
      sync_ev = ROLE_SYNC & di_rise & software_gate_request_q & ctrl_in.sync_enable_bit
         & (SYNC_PERIODIC | ~sync_once_q);
   end

   // Counting step with full signed range and limit detection.
   // A step across a limit wraps in 32 bits, so the limit test looks at the present
   // count, one step before the wrap would happen.
   always_comb begin
      step_en = int_gate & count_pulse_in;
      if (count_up_in) begin
         stepped = count_q + CGLS_STEP;
         limit_hit = (count_q == CGLS_CNT_MAX);
      end else begin
         stepped = count_q - CGLS_STEP;
         limit_hit = (count_q == CGLS_CNT_MIN);
      end
      once_close = MODE_ONCE & step_en & limit_hit;
   end

   // Counter next value; a direct load beats edge reloads, which beat counting.
   always_comb begin
      count_d = count_q;
      if (ctrl_in.load_count_stb) begin
         count_d = ctrl_in.value;
      end else if (retrig_ev || sync_ev) begin
         count_d = load_q;
      end else if (open_reload) begin
         count_d = load_q;
      end else if (step_en) begin
         if (!limit_hit) begin
            count_d = stepped;
         end else if (MODE_ONCE) begin
            // The count stays at the limit; the gate closes and needs a fresh request.
            count_d = count_q;
         end else if (MODE_PERIODIC) begin
            count_d = load_q;
         end else begin
            count_d = stepped;
         end
      end
   end

   // Every change of the count goes through count_d, so there is one place to read.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count_q <= CGLS_CNT_RST;
      end else begin
         count_q <= count_d;
      end
   end

   // The load value only ever comes from the controller, never from the counter.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         load_q <= CGLS_LOAD_RST;
      end else if (ctrl_in.load_prepare_stb) begin
         load_q <= ctrl_in.value;
      end
   end

   // Latch value changes only on a capture edge, never on loads or gate changes.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         latch_q <= CGLS_LATCH_RST;
      end else if (retrig_ev || latch_ev) begin
         latch_q <= count_q;
      end
   end

   // Once-only sync re-arms when the enable bit is withdrawn.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync_once_q <= 1'b0;
      end else if (sync_ev) begin
         sync_once_q <= 1'b1;
      end else if (!ctrl_in.sync_enable_bit) begin
         sync_once_q <= 1'b0;
      end
   end

   // A sync arriving with the reset request still sets the status.
   // Losing a sync to a coinciding clear would hide an alignment from the controller.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync_done_q <= 1'b0;
      end else if (sync_ev) begin
         sync_done_q <= 1'b1;
      end else if (ctrl_in.status_reset_request) begin
         sync_done_q <= 1'b0;
      end
   end

   // The lamp follows the done flag one cycle later, keeping the output registered.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         alignment_lamp_out <= 1'b0;
      end else begin
         alignment_lamp_out <= sync_done_q;
      end
   end

   // Feedback assembly.
   // In latching roles the value field shows the capture and the live count rides beside it.
   // Without wide feedback the live field reads zero rather than a stale count.
   always_comb begin
      fb_d = '0;
      fb_d.value = ROLE_LATCHING ? latch_q : count_q;
      fb_d.live_count = WIDE_FEEDBACK ? count_q : CGLS_CNT_RST;
      fb_d.internal_gate_status = int_gate;
      fb_d.input_level_status = di_level;
      fb_d.sync_done_status = sync_done_q;
   end

   // Snapshot register, so that isochronous feedback only moves at the input instant.
   cgls_snap u_snap (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .iso_enable_in(iso_enable_in),
      .ti_strobe_in(ti_strobe_in),
      .fb_in(fb_d),
      .fb_out(fb_q)
   );

   // The output is a plain copy of the snapshot register.
   always_comb begin
      feedback_out = fb_q;
   end

endmodule

// file: hdl/cgls_pkg.sv
// Shared types and constants for the gate, latch and synchronization control of the count unit.
package cgls_pkg;

   localparam int CGLS_CW = 32;

   // Counter range and reset values.
   localparam logic signed [CGLS_CW-1:0] CGLS_CNT_MAX = 32'sh7FFFFFFF;
   localparam logic signed [CGLS_CW-1:0] CGLS_CNT_MIN = 32'sh80000000;
   localparam logic signed [CGLS_CW-1:0] CGLS_CNT_RST = 32'sh00000000;
   localparam logic signed [CGLS_CW-1:0] CGLS_LATCH_RST = 32'sh00000000;
   localparam logic signed [CGLS_CW-1:0] CGLS_LOAD_RST = 32'sh00000000;
   localparam logic signed [CGLS_CW-1:0] CGLS_STEP = 32'sh00000001;

   // Role of the auxiliary input line.
   typedef enum logic [4:0] {
      CGLS_DI_INPUT = 5'h01,
      CGLS_DI_HWGATE = 5'h02,
      CGLS_DI_LATCH = 5'h04,
      CGLS_DI_RETRIG = 5'h08,
      CGLS_DI_SYNC = 5'h10
   } cgls_di_role_t;

   // What closing and reopening the internal gate does to the count.
   typedef enum logic [1:0] {
      CGLS_GATE_CANCEL = 2'h1,
      CGLS_GATE_INTERRUPT = 2'h2
   } cgls_gate_func_t;

   typedef enum logic [2:0] {
      CGLS_MODE_ENDLESS = 3'h1,
      CGLS_MODE_ONCE = 3'h2,
      CGLS_MODE_PERIODIC = 3'h4
   } cgls_count_mode_t;

   // Sign position of the counter; limit detection compares against the range constants instead.
   localparam int CGLS_SIGN = CGLS_CW - 1;

   // Control bits and value from the controller.
   typedef struct packed {
      logic software_gate_request;
      logic sync_enable_bit;
      logic status_reset_request;
      logic load_prepare_stb;
      logic load_count_stb;
      logic signed [CGLS_CW-1:0] value;
   } cgls_ctrl_t;

   // Feedback towards the controller.
   typedef struct packed {
      logic signed [CGLS_CW-1:0] value;
      logic signed [CGLS_CW-1:0] live_count;
      logic internal_gate_status;
      logic input_level_status;
      logic sync_done_status;
   } cgls_fb_t;

endpackage

// file: hdl/cgls_edge.sv
// Input synchroniser with optional inversion and registered edge detection.
`timescale 1ns/1ps
module cgls_edge (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic pin_in,
   input wire logic invert_in,
   output logic level_out,
   output logic rise_out,
   output logic fall_out
);
   import cgls_pkg::*;

   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Inverting after the flops keeps the reset state equal to a raw line idling low.
   // An inverted line therefore reports no false rising edge just after reset.
   // Edges compare two registered stages, so each edge is one cycle wide.
   always_comb begin
      level_out = sync_q ^ invert_in;
      rise_out = (sync_q ^ invert_in) & ~(prev_q ^ invert_in);
      fall_out = ~(sync_q ^ invert_in) & (prev_q ^ invert_in);
   end

endmodule

// file: hdl/cgls_snap.sv
// Feedback snapshot register, sampled at the input instant in isochronous operation.
`timescale 1ns/1ps
module cgls_snap (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic iso_enable_in,
   input wire logic ti_strobe_in,
   input wire cgls_pkg::cgls_fb_t fb_in,
   output cgls_pkg::cgls_fb_t fb_out
);
   import cgls_pkg::*;

   // Free running operation refreshes every cycle; isochronous only at the input instant.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fb_out <= '0;
      end else if (!iso_enable_in || ti_strobe_in) begin
         fb_out <= fb_in;
      end
   end

endmodule

// file: sim/cgls_sva.sv
// Port-level checker for the gate, latch and synchronization control block.
`timescale 1ns/1ps
module cgls_sva (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic aux_input_line_in,
   input wire logic count_pulse_in,
   input wire logic count_up_in,
   input wire logic iso_enable_in,
   input wire logic ti_strobe_in,
   input wire logic to_strobe_in,
   input wire cgls_pkg::cgls_ctrl_t ctrl_in,
   input wire cgls_pkg::cgls_fb_t feedback_out,
   input wire logic alignment_lamp_out
);
   import cgls_pkg::*;
   default clocking dcb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   // Windows are a few cycles longer than the pipeline so that the checks stay latency tolerant.
   AST_LEVEL: assert property ((!iso_enable_in && $stable(aux_input_line_in))[*5]
      |-> feedback_out.input_level_status == aux_input_line_in)
      else $error("input level status does not follow the pin");
   AST_HW_CLOSED: assert property ((!iso_enable_in && !aux_input_line_in)[*6]
      |-> !feedback_out.internal_gate_status)
      else $error("gate open while the hardware gate is low");
   AST_SW_CLOSED: assert property ((!iso_enable_in && !ctrl_in.software_gate_request)[*4]
      |-> !feedback_out.internal_gate_status)
      else $error("gate open while the gate request is low");
   AST_HOLD: assert property ((!iso_enable_in && !feedback_out.internal_gate_status
      && !ctrl_in.load_count_stb)[*4] |=> $stable(feedback_out.live_count))
      else $error("count moved with the gate closed");
   AST_STEP: assert property ((!iso_enable_in && !ctrl_in.load_count_stb)[*3] |=>
      $signed(feedback_out.live_count - $past(feedback_out.live_count)) inside {-1, 0, 1})
      else $error("count moved by more than one step");
   AST_LIVE: assert property (!iso_enable_in |->
      feedback_out.value == feedback_out.live_count)
      else $error("live count differs from count in gate role");
   AST_ISO_HOLD: assert property (iso_enable_in && $past(iso_enable_in)
      && !$past(ti_strobe_in) |-> $stable(feedback_out))
      else $error("feedback changed between input instants");
   AST_NO_SYNC: assert property (!feedback_out.sync_done_status)
      else $error("sync done set outside the sync role");
   AST_LAMP: assert property ($rose(alignment_lamp_out) && !iso_enable_in
      && !$past(iso_enable_in) |-> feedback_out.sync_done_status)
      else $error("lamp lit without sync done");
endmodule

bind cgls_top cgls_sva i_cgls_sva (
   .clk_in(clk_in),
   .nrst_in(nrst_in),
   .aux_input_line_in(aux_input_line_in),
   .count_pulse_in(count_pulse_in),
   .count_up_in(count_up_in),
   .iso_enable_in(iso_enable_in),
   .ti_strobe_in(ti_strobe_in),
   .to_strobe_in(to_strobe_in),
   .ctrl_in(ctrl_in),
   .feedback_out(feedback_out),
   .alignment_lamp_out(alignment_lamp_out)
);

// file: sim/cgls_ctl_model.sv
// Controller-side relay that packs the control bits for the block.
`timescale 1ns/1ps
module cgls_ctl_model (
   input wire logic gate_cmd_in,
   input wire logic load_stb_in,
   input wire logic signed [31:0] value_in,
   output cgls_pkg::cgls_ctrl_t ctrl_out
);
   import cgls_pkg::*;
   // Sync and status reset stay idle because the bench runs the hardware gate role.
   always_comb begin
      ctrl_out = '0;
      ctrl_out.software_gate_request = gate_cmd_in;
      ctrl_out.load_count_stb = load_stb_in;
      ctrl_out.value = value_in;
   end
endmodule

// file: sim/tb.sv
// Self-checking bench for the block in hardware gate role with interrupting gate.
`timescale 1ns/1ps
module tb;
   import cgls_pkg::*;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic pin = 1'b0;
   logic pulse = 1'b0;
   logic up = 1'b0;
   logic iso = 1'b0;
   logic ti = 1'b0;
   logic to_s = 1'b0;
   logic sw = 1'b0;
   logic ldc = 1'b0;
   logic signed [31:0] val = 32'sh00000000;
   cgls_ctrl_t ctrl;
   cgls_fb_t fb;
   logic lamp;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   int cnt = 0;
   int old = 0;
   bit g = 1'b0;

   cgls_ctl_model i_cgls_ctl_model (.gate_cmd_in(sw), .load_stb_in(ldc), .value_in(val),
      .ctrl_out(ctrl));
   cgls_top #(.DI_ROLE(CGLS_DI_HWGATE), .GATE_FUNC(CGLS_GATE_INTERRUPT),
      .SW_OPEN_RELOAD(1'b0), .HW_OPEN_RELOAD(1'b0)) i_cgls_top (
      .clk_in(clk_in), .nrst_in(nrst_in), .aux_input_line_in(pin),
      .count_pulse_in(pulse), .count_up_in(up), .iso_enable_in(iso),
      .ti_strobe_in(ti), .to_strobe_in(to_s), .ctrl_in(ctrl),
      .feedback_out(fb), .alignment_lamp_out(lamp));

   initial begin
      forever #5 clk_in = ~clk_in;
   end

   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Sampling on the falling edge keeps comparisons clear of the design's own updates.
   task automatic settle();
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
   endtask

   task automatic look(input int v, input bit gs);
      chk(fb.value, v);
      chk(fb.live_count, v);
      chk(fb.internal_gate_status, gs);
      chk(fb.input_level_status, pin);
      chk(fb.sync_done_status, 1'b0);
      chk(lamp, 1'b0);
   endtask

   task automatic steps(input int n, input bit dir);
      repeat (n) begin
         @(posedge clk_in);
         pulse <= 1'b1;
         up <= dir;
         if (g) cnt += dir ? 1 : -1;
      end
      @(posedge clk_in);
      pulse <= 1'b0;
      settle();
   endtask

   task automatic drive(input logic p, input logic s);
      @(posedge clk_in);
      pin <= p;
      sw <= s;
      settle();
   endtask

   task automatic ld(input int v);
      @(posedge clk_in);
      val <= v;
      ldc <= 1'b1;
      @(posedge clk_in);
      ldc <= 1'b0;
      cnt = v;
      settle();
   endtask

   task automatic tick(input bit o);
      @(posedge clk_in);
      if (o) to_s <= 1'b1;
      else ti <= 1'b1;
      @(posedge clk_in);
      to_s <= 1'b0;
      ti <= 1'b0;
      settle();
   endtask

   initial begin
      void'($urandom(75219));
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      settle();
      look(0, 1'b0);
      ld(int'($urandom));
      steps(3, 1'b1);
      look(cnt, 1'b0);
      drive(1'b1, 1'b0);
      steps(2, 1'b0);
      look(cnt, 1'b0);
      drive(1'b1, 1'b1);
      g = 1'b1;
      look(cnt, 1'b1);
      repeat (4) begin
         steps(1 + $urandom % 8, 1'($urandom % 2));
         look(cnt, 1'b1);
      end
      ld(32'sh7FFFFFFF);
      steps(2, 1'b1);
      look(cnt, 1'b1);
      ld(32'sh80000000);
      steps(1, 1'b0);
      look(cnt, 1'b1);
      ld(int'($urandom));
      drive(1'b0, 1'b1);
      g = 1'b0;
      steps(5, 1'b1);
      look(cnt, 1'b0);
      drive(1'b1, 1'b1);
      g = 1'b1;
      steps(2, 1'b0);
      look(cnt, 1'b1);
      drive(1'b1, 1'b0);
      g = 1'b0;
      steps(3, 1'b1);
      look(cnt, 1'b0);
      @(posedge clk_in);
      iso <= 1'b1;
      settle();
      old = cnt;
      @(posedge clk_in);
      sw <= 1'b1;
      settle();
      steps(3, 1'b1);
      tick(1'b1);
      g = 1'b1;
      steps(4, 1'b1);
      chk(fb.value, old);
      chk(fb.internal_gate_status, 1'b0);
      tick(1'b0);
      look(cnt, 1'b1);
      @(posedge clk_in);
      iso <= 1'b0;
      settle();
      summarize();
   end
endmodule
